/* enable_mask_store.sv */
`timescale 1ns/100ps
module enable_mask_store
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   mask_bus_if.store bus
);
   import irq_mask_pkg::*;

   logic [31:0] mask;
   logic [31:0] next_mask;

   // one flop per bit, shared by both ports; clear wins when both strike
   always_comb begin
      next_mask = mask;
      if (bus.set_strobe) begin
         next_mask = next_mask | (bus.write_data & mask_implemented);
      end
      if (bus.clear_strobe) begin
         next_mask = next_mask & ~bus.write_data;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         mask <= mask_reset_value;
      end else begin
         mask <= next_mask;
      end
   end

   assign bus.mask = mask;
endmodule : enable_mask_store

/* host_driver_model.sv */
`timescale 1ns/100ps
module host_driver_model
(
   input wire logic clock_in,
   input wire logic [irq_mask_pkg::reg_width-1:0] rdata_in,
   output logic write_out,
   output logic read_out,
   output logic [irq_mask_pkg::addr_width-1:0] addr_out,
   output logic [irq_mask_pkg::reg_width-1:0] wdata_out
);
   import irq_mask_pkg::*;
   initial begin
      write_out = 1'b0;
      read_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 32'h00000000;
   end
   // one strobe cycle per access, off the sampling edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clock_in);
      write_out = 1'b1;
      addr_out = a;
      wdata_out = d & mask_implemented;
      @(negedge clock_in);
      write_out = 1'b0;
      wdata_out = ~wdata_out;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      @(negedge clock_in);
      read_out = 1'b1;
      addr_out = a;
      @(negedge clock_in);
      read_out = 1'b0;
      q = rdata_in;
   endtask : rd
endmodule : host_driver_model

/* irq_mask_pkg.sv */
package irq_mask_pkg;
   localparam int unsigned reg_width = 32;
   localparam int unsigned addr_width = 8;
   localparam logic [7:0] mask_set_offset = 8'h10;
   localparam logic [7:0] mask_clear_offset = 8'h14;
   localparam logic [31:0] mask_reset_value = 32'h00000000;
   localparam logic [31:0] mask_implemented = 32'hC000007F;
   localparam int unsigned master_gate_bit = 31;
   localparam int unsigned ownership_change_bit = 30;
   localparam int unsigned root_hub_change_bit = 6;
   localparam int unsigned frame_number_overflow_bit = 5;
   localparam int unsigned unrecoverable_error_bit = 4;
   localparam int unsigned resume_detected_bit = 3;
   localparam int unsigned start_of_frame_bit = 2;
   localparam int unsigned done_head_writeback_bit = 1;
   localparam int unsigned scheduling_overrun_bit = 0;
   localparam int unsigned source_count = 31;
endpackage : irq_mask_pkg

/* mask_bus_if.sv */
`timescale 1ns/100ps
interface mask_bus_if;
   logic set_strobe;
   logic clear_strobe;
   logic [31:0] write_data;
   logic [31:0] mask;
   modport ctrl (output set_strobe, output clear_strobe, output write_data, input mask);
   modport store (input set_strobe, input clear_strobe, input write_data, output mask);
endinterface : mask_bus_if

/* tb_usb_host_irq_mask_clear.sv */
`timescale 1ns/100ps
module tb_usb_host_irq_mask_clear;
   import irq_mask_pkg::*;
   logic clock_in, reset_n_in, irq, ws, rs, hit;
   logic [31:0] flags, rdata, mask, q, model, d, wdata;
   logic [7:0] addr;
   int err_count = 0;
   int n_tests = 0;
   usb_host_irq_mask_clear u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .reg_write_in(ws), .reg_read_in(rs),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
      .event_flags_in(flags), .enable_mask_out(mask), .irq_request_out(irq));
   host_driver_model u_host (.clock_in(clock_in), .rdata_in(rdata), .write_out(ws), .read_out(rs),
      .addr_out(addr), .wdata_out(wdata));
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic exp_irq(input logic [31:0] m, input logic [31:0] f);
      return m[master_gate_bit] & (|(m[30:0] & f[30:0]));
   endfunction : exp_irq
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   task automatic verify;
      u_host.rd(mask_clear_offset, q);
      check("clear port read", q, model);
      check("hit", {31'h0, hit}, 32'h1);
      u_host.rd(mask_set_offset, q);
      check("set port read", q, model);
      check("mask", mask, model);
      check("irq", {31'h0, irq}, {31'h0, exp_irq(model, flags)});
   endtask : verify
   initial begin
      reset_n_in = 1'b0;
      flags = 32'h0;
      model = 32'h0;
      void'($urandom(68165));
      repeat (4) @(negedge clock_in);
      reset_n_in = 1'b1;
      verify();
      $display("reset test done");
      // all flags up, so the gate alone decides the request
      flags = 32'hFFFFFFFF;
      for (int b = 0; b < 32; b++) if (mask_implemented[b]) begin
         u_host.wr(mask_set_offset, 32'hFFFFFFFF);
         model = mask_implemented;
         u_host.wr(mask_clear_offset, 32'h1 << b);
         model[b] = 1'b0;
         verify();
      end
      $display("per bit test done");
      for (int i = 0; i < 60; i++) begin
         d = $urandom() & mask_implemented;
         flags = $urandom();
         if ($urandom() % 2) begin
            u_host.wr(mask_set_offset, d);
            model = model | d;
         end else begin
            u_host.wr(mask_clear_offset, d);
            model = model & ~d;
         end
         verify();
      end
      $display("random test done");
      u_host.wr(8'h18, 32'hFFFFFFFF);
      u_host.rd(8'h18, q);
      check("unmapped read", q, 32'h0);
      check("unmapped hit", {31'h0, hit}, 32'h0);
      verify();
      $display("unmapped test done");
      // reset in mid-run with every enable set must clear them all
      u_host.wr(mask_set_offset, 32'hFFFFFFFF);
      check("mask before reset", mask, mask_implemented);
      reset_n_in = 1'b0;
      repeat (4) @(negedge clock_in);
      reset_n_in = 1'b1;
      model = 32'h0;
      verify();
      $display("mid reset test done");
      wrap_up();
   end
   initial begin
      #200000;
      err_count++;
      wrap_up();
   end
endmodule : tb_usb_host_irq_mask_clear

/* usb_host_irq_mask_clear.sv */
`timescale 1ns/100ps
module usb_host_irq_mask_clear
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [irq_mask_pkg::addr_width-1:0] reg_addr_in,
   input wire logic [irq_mask_pkg::reg_width-1:0] reg_wdata_in,
   output logic [irq_mask_pkg::reg_width-1:0] reg_rdata_out,
   output logic reg_hit_out,
   input wire logic [irq_mask_pkg::reg_width-1:0] event_flags_in,
   output logic [irq_mask_pkg::reg_width-1:0] enable_mask_out,
   output logic irq_request_out
);
   import irq_mask_pkg::*;

   mask_bus_if bus ();
   logic hit_set;
   logic hit_clear;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic irq;
   logic next_irq;
   logic gate_on;
   logic owner_on;
   logic hub_on;
   logic frame_on;
   logic error_on;
   logic resume_on;
   logic sof_on;
   logic done_on;
   logic overrun_on;
   logic [source_count-1:0] source_live;

   assign hit_set = (reg_addr_in == mask_set_offset);
   assign hit_clear = (reg_addr_in == mask_clear_offset);
   assign reg_hit_out = hit_set | hit_clear;
   assign bus.set_strobe = reg_write_in & hit_set;
   // reserved bits are masked off on set writes and so stay zero, so stray ones there are harmless
   assign bus.clear_strobe = reg_write_in & hit_clear;
   assign bus.write_data = reg_wdata_in;

   enable_mask_store store_inst (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .bus(bus)
   );

   // named views of the shared mask, one per enable
   assign gate_on = bus.mask[master_gate_bit];
   assign owner_on = bus.mask[ownership_change_bit];
   assign hub_on = bus.mask[root_hub_change_bit];
   assign frame_on = bus.mask[frame_number_overflow_bit];
   assign error_on = bus.mask[unrecoverable_error_bit];
   assign resume_on = bus.mask[resume_detected_bit];
   assign sof_on = bus.mask[start_of_frame_bit];
   assign done_on = bus.mask[done_head_writeback_bit];
   assign overrun_on = bus.mask[scheduling_overrun_bit];

   // flag and enable pair bit by bit; the gate is applied once, after the or
   for (genvar i = 0; i < source_count; i++) begin : g_source
      assign source_live[i] = event_flags_in[i] & bus.mask[i];
   end

   // read data and request are registered; unmapped reads give zero
   always_comb begin
      next_rdata = mask_reset_value;
      if (reg_read_in && reg_hit_out) begin
         next_rdata = bus.mask;
      end
      // request lags the mask by one cycle, so a gate clear is felt two edges on
      next_irq = gate_on & (|source_live);
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         rdata <= mask_reset_value;
         irq <= 1'b0;
      end else begin
         rdata <= next_rdata;
         irq <= next_irq;
      end
   end

   assign reg_rdata_out = rdata;
   assign irq_request_out = irq;
   assign enable_mask_out = bus.mask;

   // clear port: ones clear, zeros keep
   clear_bit_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      bus.clear_strobe
      |=> ((bus.mask & $past(reg_wdata_in)) == 32'h00000000))
      else $error("clear write left a bit set");

   keep_bit_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && !bus.set_strobe)
      |=> ((bus.mask & ~$past(reg_wdata_in)) == ($past(bus.mask) & ~$past(reg_wdata_in))))
      else $error("clear write disturbed a zero bit");

   quiet_mask_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (!bus.set_strobe && !bus.clear_strobe)
      |=> $stable(bus.mask))
      else $error("mask moved without a write");

   stray_write_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (reg_write_in && !reg_hit_out)
      |=> $stable(bus.mask))
      else $error("write to another offset moved the mask");

   reserved_zero_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.mask & ~mask_implemented)
      == 32'h00000000)
      else $error("reserved enable bit set");

   gate_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[master_gate_bit])
      |=> !gate_on)
      else $error("master gate not cleared");

   gate_off_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[master_gate_bit])
      |=> ##1 !irq_request_out)
      else $error("interrupt after gate cleared");

   reset_zero_a: assert property (@(posedge clock_in)
      !reset_n_in
      |=> (bus.mask == 32'h00000000 && !irq_request_out && reg_rdata_out == 32'h00000000))
      else $error("mask not zero after reset");

   owner_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[ownership_change_bit])
      |=> !owner_on)
      else $error("ownership enable not cleared");

   hub_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[root_hub_change_bit])
      |=> !hub_on)
      else $error("root hub enable not cleared");

   frame_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[frame_number_overflow_bit])
      |=> !frame_on)
      else $error("frame overflow enable not cleared");

   error_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[unrecoverable_error_bit])
      |=> !error_on)
      else $error("error enable not cleared");

   resume_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[resume_detected_bit])
      |=> !resume_on)
      else $error("resume enable not cleared");

   sof_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[start_of_frame_bit])
      |=> !sof_on)
      else $error("frame start enable not cleared");

   done_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[done_head_writeback_bit])
      |=> !done_on)
      else $error("done head enable not cleared");

   overrun_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.clear_strobe && reg_wdata_in[scheduling_overrun_bit])
      |=> !overrun_on)
      else $error("overrun enable not cleared");

   // read path
   read_mask_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (reg_read_in && hit_clear && !reg_write_in)
      |=> (reg_rdata_out == $past(bus.mask)))
      else $error("read did not return mask");

   idle_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !reg_read_in
      |=> (reg_rdata_out == 32'h00000000))
      else $error("read data without a read");

   stray_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (reg_read_in && !reg_hit_out)
      |=> (reg_rdata_out == 32'h00000000))
      else $error("read of another offset gave data");

   set_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (reg_read_in && hit_set && !reg_write_in)
      |=> (reg_rdata_out == $past(bus.mask)))
      else $error("set port read differs from mask");

   // interrupt path
   irq_cause_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      irq_request_out
      |-> ($past(bus.mask[31]) && (($past(event_flags_in) & $past(bus.mask) & 32'h7FFFFFFF) != 32'h00000000)))
      else $error("interrupt without cause");

   irq_raise_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.mask[31] && ((event_flags_in & bus.mask & 32'h7FFFFFFF) != 32'h00000000))
      |=> irq_request_out)
      else $error("cause present but no interrupt");

   // set port
   set_bit_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.set_strobe && reg_wdata_in[0])
      |=> bus.mask[0])
      else $error("set write did not set bit");

   set_gate_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (bus.set_strobe && reg_wdata_in[master_gate_bit])
      |=> gate_on)
      else $error("set write did not open the gate");

   set_keep_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      bus.set_strobe
      |=> ((bus.mask & ~$past(reg_wdata_in)) == ($past(bus.mask) & ~$past(reg_wdata_in))))
      else $error("set write disturbed a zero bit");
endmodule : usb_host_irq_mask_clear
